//--- area_select_detect_output.sv
// Area selection, presence judgement, hysteresis and ON/OFF delay logic.
`timescale 1ns/100ps
module area_select_detect_output
  import area_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES = SCAN_CYC_DFLT
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Area select pins from the machine controller, low means ON
  input  wire logic [3:0]             i_area_sel_n,
  // Configuration from the setup tool
  input  wire cfg_t                   i_cfg,
  // Per-scan measurement of the selected area
  input  wire logic [MM_W-1:0]        i_area_dist,
  input  wire meas_t [NUM_REGIONS-1:0] i_meas,
  // Status to the optical front end
  output logic [3:0]                  o_area_num,
  output logic                        o_laser_en,
  output logic [MM_W-1:0]             o_hys_margin,
  output logic [NUM_REGIONS-1:0]      o_hys_active,
  output logic                        o_scan_tick,
  output logic                        o_motor_sync,
  // Detection outputs, high means ON (no object)
  output logic [NUM_REGIONS-1:0]      o_detect
);

  // ****************************************************************
  // Scan pacing and motor phase
  // ****************************************************************
  logic [SCAN_CNT_W-1:0] scan_cnt_ff;
  logic [SCAN_CNT_W-1:0] nxt_scan_cnt;
  logic [SCAN_CNT_W-1:0] sync_point;
  logic                  scan_tick;
  logic                  sync_hit;
  logic                  scan_tick_ff;
  logic                  motor_sync_ff;

  // The area take and every region judgement share this one tick, so a scan is one decision.
  assign scan_tick    = (scan_cnt_ff == SCAN_CNT_W'(SCAN_CYCLES - 1));
  assign nxt_scan_cnt = scan_tick ? '0 : scan_cnt_ff + 1'b1;
  // Sync angle phase
  // A quarter scan per 90 degree step; the motor index is delayed by this much.
  assign sync_point   = SCAN_CNT_W'((SCAN_CYCLES / 4) * i_cfg.sync_angle);
  assign sync_hit     = (scan_cnt_ff == sync_point);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scan_cnt_ff   <= '0;
      scan_tick_ff  <= 1'b0;
      motor_sync_ff <= 1'b0;
    end else begin
      scan_cnt_ff   <= nxt_scan_cnt;
      scan_tick_ff  <= scan_tick;
      motor_sync_ff <= sync_hit;
    end
  end

  assign o_scan_tick  = scan_tick_ff;
  assign o_motor_sync = motor_sync_ff;

  // ****************************************************************
  // Area decode
  // ****************************************************************
  logic [3:0] area_ff;
  logic [3:0] nxt_area;
  logic       laser_ff;
  logic       nxt_laser;

  // High pin is OFF
  // An OFF pin reads as 1, so the raw pin word already is the area number.
  assign nxt_area  = scan_tick ? i_area_sel_n : area_ff;
  assign nxt_laser = (nxt_area != AREA_LASER_OFF);

  // Taken each scan
  // Sampling once per scan keeps the change within one scan, inside the two allowed.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      area_ff  <= AREA_LASER_OFF;
      laser_ff <= 1'b0;
    end else begin
      area_ff  <= nxt_area;
      laser_ff <= nxt_laser;
    end
  end

  assign o_area_num = area_ff;
  assign o_laser_en = laser_ff;

  // ****************************************************************
  // Hysteresis margin
  // ****************************************************************
  logic [MM_W-1:0]    dist_clamp;
  logic signed [47:0] hys_num;
  logic signed [47:0] hys_val;
  logic [MM_W-1:0]    hys_ff;

  // Clamp distance range
  // The formula yields exactly min and max at the clamp points.
  assign dist_clamp = (i_area_dist < HYS_D_LO) ? HYS_D_LO :
                      (i_area_dist > HYS_D_HI) ? HYS_D_HI : i_area_dist;
  // Linear interpolation
  // Scaled to one common divisor so the two terms lose no precision separately.
  assign hys_num = 48'(HYS_DIV) * (48'(i_cfg.hys_max) - 48'(i_cfg.hys_min)) * 48'(dist_clamp)
                 + 48'(HYS_SPAN) * (48'(6) * 48'(i_cfg.hys_min) - 48'(i_cfg.hys_max));
  assign hys_val = hys_num / (48'(HYS_SPAN) * 48'(HYS_DIV));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hys_ff <= '0;
    end else begin
      hys_ff <= hys_val[MM_W-1:0];
    end
  end

  assign o_hys_margin = hys_ff;

  // ****************************************************************
  // Per-region judgement and ON/OFF delay
  // ****************************************************************
  for (genvar r = 0; r < NUM_REGIONS; r++) begin : g_region
    region_st_t       st_ff;
    region_st_t       nxt_st;
    logic [DLY_W-1:0] cnt_ff;
    logic [DLY_W-1:0] nxt_cnt;
    logic             hys_on;
    logic             present;
    logic [MM_W-1:0]  judged_width;
    logic             out_on_ff;
    logic             nxt_out_on;
    logic             hys_act_ff;
    logic             nxt_hys_act;
    logic             on_done;
    logic             off_done;

    // Enlarged boundary
    // Once an object is seen, the enlarged boundary holds until the region returns to ST_CLEAR.
    assign hys_on       = (st_ff != ST_CLEAR);
    assign judged_width = hys_on ? i_meas[r].width_hys : i_meas[r].width;
    // Minimum width
    // With the laser off nothing is present, so outputs return ON through the OFF delay.
    assign present      = laser_ff && (judged_width > i_cfg.min_width);

    // Delay code compare
    // Code n waits n+1 scans, so seven bits span 50 ms to 6400 ms.
    assign on_done      = (cnt_ff >= i_cfg.on_delay);
    assign off_done     = (cnt_ff >= i_cfg.off_delay);
    assign nxt_out_on   = (nxt_st == ST_CLEAR) || (nxt_st == ST_ON_DLY);
    assign nxt_hys_act  = (nxt_st != ST_CLEAR);

    always_comb begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      if (scan_tick) begin
        case (st_ff)
          ST_CLEAR: begin
            if (present) begin
              nxt_st  = ST_ON_DLY;
              nxt_cnt = '0;
            end
          end
          ST_ON_DLY: begin
            if (!present) begin
              nxt_st = ST_CLEAR;
            end else if (on_done) begin
              nxt_st = ST_DET;
            end else begin
              nxt_cnt = cnt_ff + 1'b1;
            end
          end
          ST_DET: begin
            if (!present) begin
              nxt_st  = ST_OFF_DLY;
              nxt_cnt = '0;
            end
          end
          ST_OFF_DLY: begin
            if (present) begin
              nxt_st = ST_DET;
            end else if (off_done) begin
              nxt_st = ST_CLEAR;
            end else begin
              nxt_cnt = cnt_ff + 1'b1;
            end
          end
          default: begin
            nxt_st = ST_CLEAR;
          end
        endcase
      end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        st_ff      <= ST_CLEAR;
        cnt_ff     <= DLY_RST;
        out_on_ff  <= 1'b1;
        hys_act_ff <= 1'b0;
      end else begin
        st_ff      <= nxt_st;
        cnt_ff     <= nxt_cnt;
        out_on_ff  <= nxt_out_on;
        hys_act_ff <= nxt_hys_act;
      end
    end

    assign o_detect[r]     = out_on_ff;
    // Taken from a flip-flop like the other status outputs, so the pin is free of decode glitches.
    assign o_hys_active[r] = hys_act_ff;
  end

endmodule // area_select_detect_output

//--- area_pkg.sv
// Constants, types and carriers for the area select and detection output block.
package area_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SCAN_MS       = 50;
  localparam int unsigned SCAN_CYC_DFLT = CLK_HZ / 1000 * SCAN_MS;
  localparam int unsigned SCAN_CNT_W    = 21;

  // ****************************************************************
  // Field widths and reset values
  // ****************************************************************
  localparam int unsigned NUM_REGIONS   = 3;
  localparam int unsigned MM_W          = 16;
  localparam int unsigned DLY_W         = 7;
  localparam logic [3:0]  AREA_LASER_OFF = 4'h0;
  localparam logic [DLY_W-1:0] DLY_RST   = 7'h00;
  localparam logic [MM_W-1:0]  HYS_D_LO  = 16'h1388;
  localparam logic [MM_W-1:0]  HYS_D_HI  = 16'h7530;
  localparam int signed   HYS_SPAN      = 25000;
  localparam int signed   HYS_DIV       = 5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_CLEAR  = 4'h1,
    ST_ON_DLY = 4'h2,
    ST_DET    = 4'h4,
    ST_OFF_DLY= 4'h8
  } region_st_t;

  typedef struct packed {
    logic [MM_W-1:0]  min_width;
    logic [MM_W-1:0]  hys_min;
    logic [MM_W-1:0]  hys_max;
    logic [DLY_W-1:0] on_delay;
    logic [DLY_W-1:0] off_delay;
    logic [1:0]       sync_angle;
  } cfg_t;

  typedef struct packed {
    logic [MM_W-1:0] width;
    logic [MM_W-1:0] width_hys;
  } meas_t;

endpackage

//--- area_monitor.sv
// Assertion checker bound to the area select and detection block.
`timescale 1ns/100ps
module area_monitor
  import area_pkg::*;
#(parameter int unsigned SCAN_CYCLES = SCAN_CYC_DFLT) (
  // Clock, reset and inputs
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [3:0]  i_area_sel_n,
  input wire cfg_t        i_cfg,
  input wire logic [15:0] i_area_dist,
  // Outputs
  input wire logic [3:0]  o_area_num,
  input wire logic        o_laser_en,
  input wire logic [15:0] o_hys_margin,
  input wire logic [2:0]  o_hys_active,
  input wire logic        o_scan_tick,
  input wire logic        o_motor_sync,
  input wire logic [2:0]  o_detect
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_area_decode: assert property (o_scan_tick |-> o_area_num == $past(i_area_sel_n))
    else $error("area");
  chk_laser_area: assert property (o_laser_en == (o_area_num != 4'h0))
    else $error("laser");
  chk_area_moment: assert property (!$stable(o_area_num) |-> o_scan_tick)
    else $error("area time");
  chk_detect_moment: assert property (!$stable(o_detect) |-> o_scan_tick)
    else $error("detect time");
  chk_hold_boundary: assert property ((~o_detect & ~o_hys_active) == 3'h0)
    else $error("boundary");
  chk_margin_low: assert property (i_area_dist <= HYS_D_LO |=> o_hys_margin == $past(i_cfg.hys_min))
    else $error("low margin");
  chk_margin_high: assert property (i_area_dist >= HYS_D_HI |=> o_hys_margin == $past(i_cfg.hys_max))
    else $error("high margin");
  chk_sync_zero: assert property (o_scan_tick && i_cfg.sync_angle == 2'h0 |=> o_motor_sync)
    else $error("sync");
endmodule // area_monitor

bind area_select_detect_output area_monitor #(.SCAN_CYCLES(SCAN_CYCLES)) u_mon (
  .i_clk        (i_clk),
  .i_rst        (i_rst),
  .i_area_sel_n (i_area_sel_n),
  .i_cfg        (i_cfg),
  .i_area_dist  (i_area_dist),
  .o_area_num   (o_area_num),
  .o_laser_en   (o_laser_en),
  .o_hys_margin (o_hys_margin),
  .o_hys_active (o_hys_active),
  .o_scan_tick  (o_scan_tick),
  .o_motor_sync (o_motor_sync),
  .o_detect     (o_detect)
);

//--- ctl_model.sv
// Machine controller model that drives the area select pins.
`timescale 1ns/100ps
module ctl_model (
  // Clock and pins
  input  wire logic  i_clk,
  output logic [3:0] o_area_sel_n
);
  initial o_area_sel_n = 4'hf;
  // High is OFF
  // An OFF pin carries its weight, so the area number leaves unchanged.
  task automatic select(input logic [3:0] area);
    @(negedge i_clk);
    o_area_sel_n = area;
  endtask
endmodule // ctl_model

//--- test_area_select_detect_output.sv
// Directed bench for the area select and detection block.
`timescale 1ns/100ps
module test_area_select_detect_output;
  import area_pkg::*;
  localparam int unsigned SC = 40;
  logic        i_clk = 1'b0, i_rst, o_laser_en, o_scan_tick, o_motor_sync;
  logic [3:0]  i_area_sel_n, o_area_num;
  logic [15:0] i_area_dist, o_hys_margin;
  logic [2:0]  o_hys_active, o_detect;
  cfg_t        i_cfg;
  meas_t [2:0] i_meas;
  int          fails, comparisons, n;
  int          dl[4] = '{3000, 5000, 17500, 40000};
  ctl_model u_ctl (.i_clk(i_clk), .o_area_sel_n(i_area_sel_n));
  area_select_detect_output #(.SCAN_CYCLES(SC)) u_dut (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_area_sel_n (i_area_sel_n),
    .i_cfg        (i_cfg),
    .i_area_dist  (i_area_dist),
    .i_meas       (i_meas),
    .o_area_num   (o_area_num),
    .o_laser_en   (o_laser_en),
    .o_hys_margin (o_hys_margin),
    .o_hys_active (o_hys_active),
    .o_scan_tick  (o_scan_tick),
    .o_motor_sync (o_motor_sync),
    .o_detect     (o_detect)
  );
  // The clock is low from its declaration, so time zero holds no false falling edge.
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic close_out;
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A scan pulse that never comes ends the run instead of hanging it.
  task automatic tick(input int k);
    repeat (k) begin
      @(negedge i_clk);
      for (n = 0; n < 99 && o_scan_tick !== 1'b1; n++) @(negedge i_clk);
      if (o_scan_tick !== 1'b1) begin
        fails++;
        close_out();
      end
    end
  endtask
  function automatic logic [15:0] hys(input int d);
    int c;
    c = d < 5000 ? 5000 : (d > 30000 ? 30000 : d);
    return 16'((5 * 500 * c + 25000 * (6 * 200 - 700)) / 125000);
  endfunction
  initial begin
    i_rst = 1'b1;
    i_cfg = '0;
    i_meas = '0;
    i_area_dist = 16'h0000;
    fails = 0;
    comparisons = 0;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    for (int a = 0; a < 16; a++) begin
      u_ctl.select(4'(a));
      tick(2);
      chk(16'(o_area_num), 16'(a));
      chk(16'(o_laser_en), 16'(a != 0));
    end
    u_ctl.select(4'h1);
    i_cfg.min_width = 16'h0064;
    i_cfg.on_delay = 7'h02;
    i_cfg.off_delay = 7'h01;
    i_meas[0] = '{16'h0064, 16'h0096};
    tick(4);
    chk(16'(o_detect), 16'h0007);
    chk(16'(o_hys_active), 16'h0000);
    i_meas[0] = '{16'h0065, 16'h0065};
    for (int k = 1; k < 5; k++) begin
      tick(1);
      chk(16'(o_detect), k > 3 ? 16'h0006 : 16'h0007);
    end
    i_meas[0] = '{16'h0000, 16'h0096};
    tick(3);
    chk(16'(o_detect), 16'h0006);
    chk(16'(o_hys_active), 16'h0001);
    i_meas[0] = '0;
    for (int k = 1; k < 4; k++) begin
      tick(1);
      chk(16'(o_detect), k > 2 ? 16'h0007 : 16'h0006);
    end
    chk(16'(o_hys_active), 16'h0000);
    i_cfg.hys_min = 16'h00c8;
    i_cfg.hys_max = 16'h02bc;
    for (int i = 0; i < 4; i++) begin
      i_area_dist = 16'(dl[i]);
      repeat (2) @(negedge i_clk);
      chk(o_hys_margin, hys(dl[i]));
    end
    for (int a = 0; a < 4; a++) begin
      i_cfg.sync_angle = 2'(a);
      tick(2);
      @(negedge i_clk);
      for (n = 1; n < 60 && o_motor_sync !== 1'b1; n++) @(negedge i_clk);
      chk(16'(n), 16'(1 + a * SC / 4));
    end
    i_rst = 1'b1;
    @(negedge i_clk);
    chk(16'({o_area_num, o_laser_en, o_detect}), 16'h0007);
    i_rst = 1'b0;
    tick(2);
    chk(16'(o_area_num), 16'h0001);
    close_out();
  end
endmodule // test_area_select_detect_output
